// >>> design/pcs_defs.svh
// Constants of the peripheral clock select block: offsets, field positions, reset values.
// Assumes inclusion by bare name from the package and the top module.
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH

// ==========================================================
// Register offsets (byte addresses on APB)
`define PCS_CTRL_OFS 8'h00
`define PCS_STAT_OFS 8'h04

// ==========================================================
// Field positions of wait_and_clock_control
`define PCS_FIX_MSB 7
`define PCS_FIX_LSB 6
`define PCS_HALVE_BIT 5
`define PCS_RSV4_BIT 4
`define PCS_WMODE_MSB 3
`define PCS_WMODE_LSB 2
`define PCS_WCNT_MSB 1
`define PCS_WCNT_LSB 0

// ==========================================================
// Reset values
`define PCS_CTRL_RST 8'hc8
`define PCS_FIX_ONES 2'h3
`define PCS_WMODE_RST 2'h2
`define PCS_WCNT_RST 2'h0

`endif

// >>> design/pcs_pkg.sv
// Types of the peripheral clock select block.
// Assumes pcs_defs.svh is on the include path.
package pcs_pkg;
  `include "pcs_defs.svh"

  // ==========================================================
  // Wait settings handed to the wait-state controller
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] count;
  } pcs_wait_t;

  // APB read answer
  typedef struct packed {
    logic [31:0] data;
    logic err;
  } pcs_rd_t;
endpackage

// >>> design/pcs_top.sv
// Peripheral clock select: control register on APB, undivided or halved peripheral clock enable,
// wait settings forwarded to the wait-state controller.
// Assumes pclk is the system clock taken straight from the oscillator input, and that hw_standby
// comes from a pin outside this clock domain.
`timescale 1ns/1ps
`include "pcs_defs.svh"

// What this block does
// - The system clock runs at the oscillator input frequency, neither multiplied nor divided.
// - The peripheral clock is the system clock when the halve bit is 0 and half of it when 1.
// - The control register loads 0xc8 on reset and on entry to hardware standby.
// - Software standby leaves every control register bit unchanged.
// - Bits 7 and 6 read as 1 and ignore writes.
// - Bit 4 is a plain read/write bit that resets to 0.
// - Bits 3:2 hold wait mode (reset 10), bits 1:0 wait count (reset 00), both sent to the wait controller.
module pcs_top (
  // System clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Power modes
  input wire logic hw_standby,
  input wire logic sw_standby,
  // Clock and wait outputs
  output logic periph_clk_en,
  output pcs_pkg::pcs_wait_t wait_ctl
);
  import pcs_pkg::*;

  // ==========================================================
  // Standby pin synchroniser
  logic hwsb_s1_reg, hwsb_s2_reg;

  // Two stages; only the second is read by logic
  // Both reset to 0 so no false standby wipes the register just after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hwsb_s1_reg <= 1'b0;
      hwsb_s2_reg <= 1'b0;
    end else begin
      hwsb_s1_reg <= hw_standby;
      hwsb_s2_reg <= hwsb_s1_reg;
    end
  end

  // ==========================================================
  // APB slave and control register
  logic halve_reg, halve_next;
  logic rsv4_reg, rsv4_next;
  logic [1:0] wmode_reg, wmode_next;
  logic [1:0] wcnt_reg, wcnt_next;
  logic pready_reg, pready_next;
  pcs_rd_t rd_reg, rd_next;
  pcs_wait_t wait_reg, wait_next;
  logic [7:0] ctrl_view;
  logic [1:0] stat_view;
  logic wr_hit;
  logic act_reg, act_next;
  logic phase_reg, phase_next;
  logic en_reg, en_next;

  // Reset image of the register; single bits are picked from it so every load keeps its own width
  localparam logic [7:0] CTRL_RST = `PCS_CTRL_RST;

  // Fixed ones in the top bits; writes never reach them
  assign ctrl_view = {`PCS_FIX_ONES, halve_reg, rsv4_reg, wmode_reg, wcnt_reg};
  assign stat_view = {act_reg, phase_reg};
  // A write lands only at the completing access edge
  assign wr_hit = psel && penable && pready_reg && pwrite && pstrb[0] && (paddr == `PCS_CTRL_OFS);

  // One wait state per access keeps every bus output on a flop
  always_comb begin
    pready_next = psel && penable && !pready_reg;
    rd_next = '{data: 32'h0, err: 1'b0};
    if (psel && penable && !pready_reg) begin
      case (paddr)
        `PCS_CTRL_OFS: rd_next.data = {24'h0, ctrl_view};
        `PCS_STAT_OFS: rd_next.data = {30'h0, stat_view};
        default: rd_next.err = 1'b1;
      endcase
      if (pwrite) begin
        rd_next.data = 32'h0;
      end
    end
    halve_next = halve_reg;
    rsv4_next = rsv4_reg;
    wmode_next = wmode_reg;
    wcnt_next = wcnt_reg;
    // Software standby is not looked at: contents simply hold
    // Synchronised hardware standby wins over a write in the same cycle, as a reset would
    if (hwsb_s2_reg) begin
      halve_next = CTRL_RST[`PCS_HALVE_BIT];
      rsv4_next = CTRL_RST[`PCS_RSV4_BIT];
      wmode_next = `PCS_WMODE_RST;
      wcnt_next = `PCS_WCNT_RST;
    end else if (wr_hit) begin
      halve_next = pwdata[`PCS_HALVE_BIT];
      rsv4_next = pwdata[`PCS_RSV4_BIT];
      wmode_next = pwdata[`PCS_WMODE_MSB:`PCS_WMODE_LSB];
      wcnt_next = pwdata[`PCS_WCNT_MSB:`PCS_WCNT_LSB];
    end
    wait_next = '{mode: wmode_next, count: wcnt_next};
  end

  // Register stage of the bus and control group
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      rd_reg <= '{data: 32'h0, err: 1'b0};
      halve_reg <= 1'b0;
      rsv4_reg <= 1'b0;
      wmode_reg <= `PCS_WMODE_RST;
      wcnt_reg <= `PCS_WCNT_RST;
      wait_reg <= '{mode: `PCS_WMODE_RST, count: `PCS_WCNT_RST};
    end else begin
      pready_reg <= pready_next;
      rd_reg <= rd_next;
      halve_reg <= halve_next;
      rsv4_reg <= rsv4_next;
      wmode_reg <= wmode_next;
      wcnt_reg <= wcnt_next;
      wait_reg <= wait_next;
    end
  end

  // ==========================================================
  // Peripheral clock enable
  // The applied selection moves only when phase is 0, i.e. after a full halved period,
  // so a peripheral never sees a cut-short cycle; costs up to one cycle of latency.
  // Peripherals get an enable, not a gated clock, so each of their flops must be qualified by it.
  always_comb begin
    act_next = act_reg;
    if (!phase_reg) begin
      act_next = halve_reg;
    end
    phase_next = act_next ? !phase_reg : 1'b0;
    en_next = act_next ? phase_next : 1'b1;
  end

  // Register stage of the divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_reg <= 1'b0;
      phase_reg <= 1'b0;
      en_reg <= 1'b1;
    end else begin
      act_reg <= act_next;
      phase_reg <= phase_next;
      en_reg <= en_next;
    end
  end

  // Outputs straight from flops
  assign pready = pready_reg;
  assign prdata = rd_reg.data;
  assign pslverr = rd_reg.err;
  assign periph_clk_en = en_reg;
  assign wait_ctl = wait_reg;

  // ==========================================================
  // Checks
  // All checks rest while reset is low; write checks look only at the completing access edge, the read check at the edge before it.
  // Standby checks use the synchronised pin, since that is what the register logic sees.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_UNDIV_EVERY_CYCLE: assert property (!act_reg |-> en_reg)
    else $error("enable dropped while undivided");
  AST_HALF_ALTERNATES: assert property (act_reg && $past(act_reg) |-> en_reg != $past(en_reg))
    else $error("halved enable does not alternate");
  AST_HALVE_APPLIED: assert property ($rose(halve_reg) |-> ##[1:2] act_reg)
    else $error("halve bit not applied in time");
  AST_HWSB_LOADS: assert property (hwsb_s2_reg |=> ctrl_view == `PCS_CTRL_RST)
    else $error("hardware standby did not load reset value");
  AST_SWSB_HOLDS: assert property (sw_standby && !wr_hit && !hwsb_s2_reg |=> $stable(ctrl_view))
    else $error("register changed in software standby");
  AST_TOP_ONES: assert property (psel && penable && !pready_reg && !pwrite && paddr == `PCS_CTRL_OFS
    |=> prdata[7:6] == 2'h3)
    else $error("top bits not read as one");
  AST_RSV4_WRITE: assert property (wr_hit && !hwsb_s2_reg |=> rsv4_reg == $past(pwdata[4]))
    else $error("bit 4 write lost");
  AST_WAIT_FWD: assert property (wr_hit && !hwsb_s2_reg |=> wait_ctl == {$past(pwdata[3:0])})
    else $error("wait settings not forwarded");
  AST_NO_SHORT: assert property (!en_reg |=> en_reg)
    else $error("peripheral clock low for two cycles");

  // Clearing the halve bit returns to the undivided clock at the next phase-0 point
  AST_HALVE_RELEASED: assert property ($fell(halve_reg) |-> ##[1:2] !act_reg)
    else $error("halve bit clear not applied in time");

  // A completed write moves the halve bit to the written value
  AST_HALVE_WRITE: assert property (wr_hit && !hwsb_s2_reg |=> halve_reg == $past(pwdata[`PCS_HALVE_BIT]))
    else $error("halve bit write lost");

  // Hardware standby also hands the reset wait settings to the wait controller
  AST_HWSB_WAIT: assert property (hwsb_s2_reg |=> wait_ctl == {`PCS_WMODE_RST, `PCS_WCNT_RST})
    else $error("hardware standby did not reload wait settings");

  // Software standby alone never disturbs the forwarded wait settings
  AST_SWSB_WAIT: assert property (sw_standby && !wr_hit && !hwsb_s2_reg |=> $stable(wait_ctl))
    else $error("wait settings changed in software standby");

  // Bit 4 returns to zero whenever hardware standby is seen
  AST_RSV4_CLEARED: assert property (hwsb_s2_reg |=> !rsv4_reg)
    else $error("bit 4 not cleared by hardware standby");

  // Scenarios worth seeing: both halving directions, standby reload, an error answer, standby while halved

  COV_HALVE_ON: cover property ($rose(act_reg));
  COV_HALVE_OFF: cover property ($fell(act_reg));
  COV_HWSB: cover property (hwsb_s2_reg && !halve_reg ##1 1'b1);
  COV_UNMAPPED: cover property (pready_reg && pslverr);
  COV_SWSB_HALVED: cover property (sw_standby && act_reg);
endmodule

// >>> testbench/peripheral_clock_select_test.sv
// Self-checking bench for the peripheral clock select block.
// Assumes the design files are compiled first; the bench drives APB and power pins itself.
`timescale 1ns/1ps
module peripheral_clock_select_test;
  import pcs_pkg::*;
  // ==========================================
  // Design pins and bench state
  logic pclk, presetn, psel, penable, pwrite, hw_standby, sw_standby;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic pready, pslverr, periph_clk_en, er, e0;
  pcs_wait_t wait_ctl;
  logic [7:0] shadow;
  int errors, samples_checked;

  pcs_top i_pcs_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .hw_standby(hw_standby), .sw_standby(sw_standby), .periph_clk_en(periph_clk_en), .wait_ctl(wait_ctl));

  // 200 MHz system clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Case equality so an unknown never passes
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("Checks %0d, errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One APB transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle count is assumed; only the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read back the control register and compare with the bench's own copy
  task automatic rdchk;
    apb(1'b0, 8'h00, 32'h0, 4'h0);
    check(rd, {24'h0, shadow});
    check(er, 1'b0);
    check(32'(wait_ctl), {28'h0, shadow[3:0]});
  endtask

  // Write, mirror the landing bits, read back, then watch the peripheral clock enable
  task automatic wr(input logic [7:0] v, input logic [3:0] s);
    apb(1'b1, 8'h00, {24'h0, v}, s);
    if (s[0]) shadow = {2'b11, v[5:0]};
    rdchk();
    repeat (4) begin
      @(posedge pclk);
      e0 = periph_clk_en;
      @(posedge pclk);
      check({31'h0, periph_clk_en}, {31'h0, shadow[5] ? ~e0 : 1'b1});
    end
    // Status bit 1 shows the applied halving once the switch has settled
    apb(1'b0, 8'h04, 32'h0, 4'h0);
    check(rd[31:1], {30'h0, shadow[5]});
    check(er, 1'b0);
  endtask

  // Watchdog far beyond the few hundred cycles the run needs
  initial begin
    #50000;
    errors++;
    stop_test();
  end

  initial begin
    {presetn, psel, penable, pwrite, hw_standby, sw_standby} = 6'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    errors = 0;
    samples_checked = 0;
    shadow = 8'hc8;
    void'($urandom(57222));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdchk();
    // Corners: all ones, all zeros, a write with the low strobe off
    wr(8'hff, 4'hf);
    wr(8'h00, 4'hf);
    wr(8'h3f, 4'he);
    repeat (16) wr(8'($urandom), 4'($urandom));
    // Unmapped address errors; the status word ignores writes
    apb(1'b0, 8'h08, 32'h0, 4'h0);
    check(er, 1'b1);
    apb(1'b1, 8'h04, 32'hff, 4'hf);
    check(er, 1'b0);
    rdchk();
    // Software standby keeps everything
    wr(8'h27, 4'hf);
    sw_standby <= 1'b1;
    repeat (5) @(posedge pclk);
    rdchk();
    sw_standby <= 1'b0;
    rdchk();
    // Hardware standby reloads the reset value
    hw_standby <= 1'b1;
    repeat (4) @(posedge pclk);
    shadow = 8'hc8;
    rdchk();
    hw_standby <= 1'b0;
    repeat (3) @(posedge pclk);
    // Reset in mid-run from a halved setting
    wr(8'h35, 4'hf);
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    shadow = 8'hc8;
    wr(8'hc8, 4'h0);
    stop_test();
  end
endmodule
